//--- src/adc_mux_serial_control.sv
`include "adc_mux_consts.svh"
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// - shift data in while select high
// - first bit enables channel after on-delay
// - enable low: all channels off after off-delay
// - next three bits address the channel
// - address is plain binary, msb first
// - result is unipolar straight binary
// - drive shared wire by sixth falling edge
// - mux and converter selects act independently
// - converter powered from select low until conversion ends
// - converter fully off while select high
// - sampling ends on second falling edge
// - hold then convert for twelve cycles
// - change on falling, sample on rising
// - keep only the last four bits
// - null bit, then result; channel stays on
module adc_mux_serial_control (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic shift_clk,
  input wire logic mux_select,
  input wire logic converter_select,
  input wire logic data_in,
  input wire adc_mux_pkg::result_t conv_result,
  input wire logic four_chan_mode,
  output logic data_out,
  output logic data_out_en_n,
  output adc_mux_pkg::chan_mask_t chan_on,
  output logic sample_on,
  output logic converter_power,
  output logic conv_active
);
  import adc_mux_pkg::*;

  // ----------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------
  logic [2:0] sync1_reg, sync1_next, sync2_reg, sync2_next;
  logic sclk_d_reg, sclk_d_next, mux_d_reg, mux_d_next;
  logic din_s1_reg, din_s1_next, din_s2_reg, din_s2_next;
  logic sclk_rise, sclk_fall, mux_fall;

  always_comb begin
    sync1_next = {shift_clk, mux_select, converter_select};
    sync2_next = sync1_reg;
    sclk_d_next = sync2_reg[2];
    mux_d_next = sync2_reg[1];
    din_s1_next = data_in;
    din_s2_next = din_s1_reg;
    if (!reset_n) begin
      // idle levels: shift clock low, selects high
      sync1_next = 3'h3;
      sync2_next = 3'h3;
      sclk_d_next = 1'b0;
      mux_d_next = 1'b1;
      din_s1_next = 1'b0;
      din_s2_next = 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    sync1_reg <= sync1_next;
    sync2_reg <= sync2_next;
    sclk_d_reg <= sclk_d_next;
    mux_d_reg <= mux_d_next;
    din_s1_reg <= din_s1_next;
    din_s2_reg <= din_s2_next;
  end

  assign sclk_rise = sync2_reg[2] && !sclk_d_reg;
  assign sclk_fall = !sync2_reg[2] && sclk_d_reg;
  assign mux_fall = !sync2_reg[1] && mux_d_reg;

  // ----------------------------------------------------------
  // input word and multiplexer control
  // ----------------------------------------------------------
  logic [3:0] word_reg, word_next;
  chan_mask_t chan_reg, chan_next;
  logic [7:0] dly_reg, dly_next;
  logic pend_reg, pend_next;

  always_comb begin
    word_next = word_reg;
    chan_next = chan_reg;
    dly_next = dly_reg;
    pend_next = pend_reg;
    if (sync2_reg[1] && sclk_rise) begin
      word_next = {word_reg[2:0], din_s2_reg};
    end
    if (mux_fall) begin
      pend_next = 1'b1;
      dly_next = 8'h00;
    end else if (pend_reg) begin
      dly_next = dly_reg + 8'h01;
      if (dly_reg == 8'(`CHAN_OFF_CYCLES - 1)) begin
        chan_next = '0;
        if (!word_reg[3]) begin
          pend_next = 1'b0;
        end
      end
      if (word_reg[3] && dly_reg == 8'(`CHAN_ON_CYCLES - 1)) begin
        pend_next = 1'b0;
        if (!(four_chan_mode && word_reg[2])) begin
          chan_next = chan_mask_t'(8'h01 << word_reg[2:0]);
        end
      end
    end
    if (!reset_n) begin
      word_next = 4'h0;
      chan_next = '0;
      dly_next = 8'h00;
      pend_next = 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    word_reg <= word_next;
    chan_reg <= chan_next;
    dly_reg <= dly_next;
    pend_reg <= pend_next;
  end

  assign chan_on = chan_reg; // stays on until the off-delay after the next select fall

  // ----------------------------------------------------------
  // converter sequence, independent of mux select
  // ----------------------------------------------------------
  conv_state_e st_reg, st_next;
  logic [3:0] cnt_reg, cnt_next;
  result_t res_reg, res_next;
  logic dout_reg, dout_next, drive_reg, drive_next, smp_reg, smp_next;
  logic [7:0] on_cnt_reg, on_cnt_next;

  always_comb begin
    st_next = st_reg;
    cnt_next = cnt_reg;
    res_next = res_reg;
    dout_next = dout_reg;
    drive_next = drive_reg;
    smp_next = smp_reg;
    on_cnt_next = on_cnt_reg;
    case (st_reg)
      st_idle: begin
        if (!sync2_reg[0]) begin
          st_next = st_sample;
          cnt_next = 4'h0;
          on_cnt_next = 8'h00;
          smp_next = 1'b0;
        end
      end
      st_sample: begin
        if (on_cnt_reg != 8'(`CHAN_ON_CYCLES)) begin
          on_cnt_next = on_cnt_reg + 8'h01;
        end else begin
          smp_next = 1'b1;
        end
        if (sclk_fall) begin
          cnt_next = cnt_reg + 4'h1;
          if (cnt_reg == 4'(`DRIVE_FALL - 1)) begin
            drive_next = 1'b1;
            dout_next = 1'b0;
          end
          if (cnt_reg == 4'(`SAMPLE_FALLS - 1)) begin
            smp_next = 1'b0; // hold; conversion starts on next falling edge
            st_next = st_null;
            cnt_next = 4'h0;
            dout_next = 1'b0; // null bit
          end
        end
      end
      st_null: begin
        if (sclk_fall) begin
          res_next = conv_result; // unipolar straight binary
          dout_next = conv_result[11];
          st_next = st_msb;
          cnt_next = 4'h0;
        end
      end
      st_msb: begin
        if (sclk_fall) begin
          cnt_next = cnt_reg + 4'h1;
          if (cnt_reg == 4'(`CONV_CYCLES - 1)) begin
            st_next = st_lsb; // twelve cycles
            cnt_next = 4'h1;
            dout_next = res_reg[1];
          end else begin
            dout_next = res_reg[4'(10) - cnt_reg];
          end
        end
      end
      st_lsb: begin
        if (sclk_fall) begin
          cnt_next = cnt_reg + 4'h1;
          if (cnt_reg == 4'(`RESULT_BITS - 1)) begin
            st_next = st_zero;
            dout_next = 1'b0; // zeros after result
          end else begin
            dout_next = res_reg[cnt_reg + 4'h1];
          end
        end
      end
      st_zero: begin
        dout_next = 1'b0;
      end
      default: begin
        st_next = st_idle;
      end
    endcase
    if (sync2_reg[0]) begin
      st_next = st_idle;
      drive_next = 1'b0;
      smp_next = 1'b0;
      dout_next = 1'b0;
    end
    if (!reset_n) begin
      st_next = st_idle;
      cnt_next = 4'h0;
      res_next = '0;
      dout_next = 1'b0;
      drive_next = 1'b0;
      smp_next = 1'b0;
      on_cnt_next = 8'h00;
    end
  end

  always_ff @(posedge core_clk) begin
    st_reg <= st_next;
    cnt_reg <= cnt_next;
    res_reg <= res_next;
    dout_reg <= dout_next;
    drive_reg <= drive_next;
    smp_reg <= smp_next;
    on_cnt_reg <= on_cnt_next;
  end

  assign data_out = dout_reg;
  assign data_out_en_n = !drive_reg; // host has released wire
  assign sample_on = smp_reg;
  assign conv_active = (st_reg == st_msb);
  assign converter_power = (st_reg == st_sample) || (st_reg == st_null) ||
                           (st_reg == st_msb);

  // ----------------------------------------------------------
  // checks
  // ----------------------------------------------------------
  idle_powered_down_a: assert property (@(posedge core_clk)
    disable iff (!reset_n) sync2_reg[0] |=> !converter_power)
    else $error("converter powered with select high");

  release_wire_a: assert property (@(posedge core_clk)
    disable iff (!reset_n) sync2_reg[0] |=> data_out_en_n)
    else $error("data wire driven with select high");

  drive_by_sixth_a: assert property (@(posedge core_clk)
    disable iff (!reset_n)
    (st_reg == st_sample && sclk_fall && cnt_reg == 4'h0) |=>
    !data_out_en_n)
    else $error("wire not driven after first falling edge");

  shift_word_a: assert property (@(posedge core_clk)
    disable iff (!reset_n) (sync2_reg[1] && sclk_rise) |=>
    word_reg[0] == $past(din_s2_reg) &&
    word_reg[3:1] == $past(word_reg[2:0]))
    else $error("input word not shifted");

  all_off_a: assert property (@(posedge core_clk)
    disable iff (!reset_n) (mux_fall && !word_reg[3]) |-> ##3 chan_on == '0)
    else $error("channels not switched off");

  chan_decode_a: assert property (@(posedge core_clk)
    disable iff (!reset_n) (pend_reg && word_reg[3] && !four_chan_mode &&
    dly_reg == 8'(`CHAN_ON_CYCLES - 1) && !mux_fall) |=>
    chan_on == chan_mask_t'(8'h01 << word_reg[2:0]))
    else $error("wrong channel decoded");

  hold_start_a: assert property (@(posedge core_clk)
    disable iff (!reset_n) (st_reg == st_sample && sclk_fall &&
    cnt_reg == 4'h1 && !sync2_reg[0]) |=> !sample_on && st_reg == st_null)
    else $error("hold not entered on second falling edge");

  null_bit_a: assert property (@(posedge core_clk)
    disable iff (!reset_n) (st_reg == st_null) |-> !data_out)
    else $error("null bit not low");

  lsb_zeros_a: assert property (@(posedge core_clk)
    disable iff (!reset_n) (st_reg == st_zero) |-> !data_out)
    else $error("trailing bits not zero");

  blocked_code_a: assert property (@(posedge core_clk)
    disable iff (!reset_n) (pend_reg && word_reg[3] && word_reg[2] &&
    four_chan_mode && dly_reg == 8'(`CHAN_ON_CYCLES - 1) && !mux_fall) |=>
    chan_on == '0)
    else $error("blocked code switched a channel on");

  power_off_end_a: assert property (@(posedge core_clk)
    disable iff (!reset_n) (st_reg == st_msb && sclk_fall &&
    cnt_reg == 4'(`CONV_CYCLES - 1) && !sync2_reg[0]) |=>
    !converter_power && !conv_active)
    else $error("converter still powered after conversion");
endmodule

`default_nettype wire

//--- src/adc_mux_consts.svh
`ifndef ADC_MUX_CONSTS_SVH
`define ADC_MUX_CONSTS_SVH

// ------------------------------------------------------------
// widths and counts
// ------------------------------------------------------------
`define WORD_BITS 4
`define ADDR_BITS 3
`define CHAN_COUNT 8
`define RESULT_BITS 12
`define CONV_CYCLES 12
`define SAMPLE_FALLS 2
`define DRIVE_FALL 1
`define CLK_PERIOD_NS 25
`define CHAN_ON_DELAY_NS 100
`define CHAN_OFF_DELAY_NS 50
`define CHAN_ON_CYCLES ((`CHAN_ON_DELAY_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CHAN_OFF_CYCLES ((`CHAN_OFF_DELAY_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

//--- src/adc_mux_pkg.sv
package adc_mux_pkg;
  typedef enum logic [2:0] {
    st_idle = 3'b000,
    st_sample = 3'b001,
    st_null = 3'b010,
    st_msb = 3'b011,
    st_lsb = 3'b100,
    st_zero = 3'b101
  } conv_state_e;
  typedef logic [7:0] chan_mask_t;
  typedef logic [11:0] result_t;
endpackage

//--- verification/host_model.sv
`timescale 1ns/1ps
`default_nettype none
// ------
// host serial port
// ------
module host_model (
  input wire logic core_clk,
  input wire logic data_wire,
  output logic shift_clk,
  output logic mux_select,
  output logic converter_select,
  output logic host_drv,
  output logic host_bit
);
  logic [31:0] rx;
  int nf;
  initial begin
    shift_clk = 0;
    mux_select = 0;
    converter_select = 1;
    host_drv = 0;
    host_bit = 0;
    rx = '0;
    nf = 0;
  end
  task automatic half(input int n);
    repeat (n) @(negedge core_clk);
  endtask
  task automatic load(input logic [5:0] bits, input int n);
    mux_select = 1;
    converter_select = 1;
    half(2);
    host_drv = 1;
    for (int i = n - 1; i >= 0; i--) begin
      host_bit = bits[i];
      half(4);
      shift_clk = 1;
      half(4);
      shift_clk = 0;
    end
    half(2);
  endtask
  task automatic start(input logic both);
    host_drv = 0;
    half(1);
    converter_select = 0;
    if (both) mux_select = 0;
    half(8);
    nf = 0;
  endtask
  task automatic clock_out(input int n);
    for (int i = 0; i < n; i++) begin
      half(4);
      shift_clk = 1;
      half(3);
      if (i > 0) rx[nf + i - 1] = data_wire;
      half(1);
      shift_clk = 0;
    end
    half(7);
    rx[nf + n - 1] = data_wire;
    nf += n;
  endtask
  task automatic finish();
    converter_select = 1;
    half(4);
  endtask
endmodule
`default_nettype wire

//--- verification/tb.sv
`timescale 1ns/1ps
`default_nettype none
// ------
// bench top
// ------
module tb;
  import adc_mux_pkg::*;
  logic core_clk, reset_n, shift_clk, mux_select, converter_select;
  logic data_in, four_chan_mode, data_out, data_out_en_n, sample_on;
  logic converter_power, conv_active, host_drv, host_bit, flip;
  result_t conv_result;
  chan_mask_t chan_on;
  int num_errors, check_count;
  // released wire shows a changing pattern
  assign data_in = host_drv ? host_bit : (data_out_en_n ? flip : data_out);
  adc_mux_serial_control adc_mux_serial_control_i (.core_clk, .reset_n,
    .shift_clk, .mux_select, .converter_select, .data_in, .conv_result,
    .four_chan_mode, .data_out, .data_out_en_n, .chan_on, .sample_on,
    .converter_power, .conv_active);
  host_model host_model_i (.core_clk, .data_wire(data_in), .shift_clk,
    .mux_select, .converter_select, .host_drv, .host_bit);
  initial begin
    core_clk = 0;
    forever #12.5 core_clk = ~core_clk;
  end
  always @(posedge core_clk) flip <= ~flip;
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  function automatic logic [31:0] exp_rx(input result_t r);
    exp_rx = '0;
    for (int i = 0; i < 12; i++) exp_rx[2 + i] = r[11 - i];
    for (int i = 1; i < 12; i++) exp_rx[13 + i] = r[i];
  endfunction
  task automatic frame(input logic [5:0] bits, input int n, input result_t r,
      input chan_mask_t on, input logic reload);
    conv_result = r;
    if (reload) begin
      host_model_i.load(bits, n);
      check(converter_power, 0);
    end
    host_model_i.start(reload);
    check(chan_on, on);
    check({sample_on, converter_power}, 2'b11);
    host_model_i.clock_out(2);
    check(data_out_en_n, 0);
    check({sample_on, conv_active}, 2'b00);
    host_model_i.clock_out(1);
    check(conv_active, 1);
    host_model_i.clock_out(11);
    check({conv_active, converter_power}, 2'b11);
    host_model_i.clock_out(1);
    check({conv_active, converter_power}, 0);
    host_model_i.clock_out(13);
    check(host_model_i.rx, exp_rx(r));
    host_model_i.finish();
    check({data_out_en_n, converter_power}, 2'b10);
    check(chan_on, on);
  endtask
  initial begin
    reset_n = 0;
    four_chan_mode = 0;
    conv_result = '0;
    flip = 0;
    num_errors = 0;
    check_count = 0;
    repeat (5) @(negedge core_clk);
    check({chan_on, data_out_en_n, sample_on, converter_power}, 11'h004);
    reset_n = 1;
    repeat (3) @(negedge core_clk);
    for (int i = 0; i < 8; i++) begin
      frame({3'b011, 3'(i)}, 6, 12'h5a6 ^ {4{3'(i)}}, 8'h01 << i, 1);
    end
    frame(6'h07, 4, 12'hfff, 8'h00, 1);
    four_chan_mode = 1;
    frame(6'h0d, 4, 12'h000, 8'h00, 1);
    frame(6'h0b, 4, 12'h801, 8'h08, 1);
    frame(6'h0b, 4, 12'h3c5, 8'h08, 0);
    end_of_test();
  end
  initial begin
    repeat (30000) @(posedge core_clk);
    num_errors++;
    end_of_test();
  end
  task automatic end_of_test();
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
endmodule
`default_nettype wire
